// >>> kbd_mode_ctrl.v
// Keyboard mode, lock indicator, backlight and key code translation
`timescale 1ns/1ns
`include "kbd_mode_regs.vh"
module kbd_mode_ctrl (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // APB slave
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output wire pready_out,
   output reg pslverr_out,
   // Key events from the matrix scanner
   input wire key_valid_in,
   input wire [6:0] key_id_in,
   input wire key_make_in,
   output wire key_ready_out,
   // Host restart pin, low while the host reboots
   input wire host_rst_n_in,
   // Codes to the host
   output reg code_valid_out,
   output reg [7:0] code_out,
   output reg code_make_out,
   // Indicators and backlight
   output wire caps_led_out,
   output wire second_led_out,
   output wire numlock_out,
   output wire [1:0] backlight_level_out,
   output wire backlight_on_out
);

   // ****************************************
   // Declarations
   // ****************************************

   // Sequencer states
   localparam ST_IDLE = 1'b0;
   localparam ST_BRK = 1'b1;

   // Control register and derived keyboard type
   reg [31:0] ctrl;
   wire large_kbd;

   // Mode state
   reg caps;
   reg numlock;
   reg armed;
   reg [1:0] bl_level;
   reg shift_held;
   reg ctrl_held;
   reg state;

   // Host restart handling
   wire host_rst_n_sync;
   reg host_rst_n_last;
   wire host_restart;

   // Accepted key event
   wire take;
   wire take_make;
   wire take_break;

   // Translation results for a press
   reg [7:0] next_code;
   reg next_caps;
   reg next_numlock;
   reg next_armed;
   reg [1:0] next_bl_level;

   // Released key code from memory
   wire [7:0] brk_code;

   // APB decode
   wire apb_setup;
   wire apb_write;
   wire hit_ctrl;
   wire hit_status;
   wire [31:0] status_word;

   // ****************************************
   // Host restart pin synchroniser
   // ****************************************
   kbd_pin_sync #(
      .RST_VAL(1'b1)
   ) u_host_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pin_in(host_rst_n_in),
      .level_out(host_rst_n_sync)
   );

   // Restart event is the falling edge of the filtered level
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_rst_n_last <= 1'b1;
      end else begin
         host_rst_n_last <= host_rst_n_sync;
      end
   end

   assign host_restart = host_rst_n_last & ~host_rst_n_sync;

   // ****************************************
   // Key event acceptance
   // ****************************************

   // Ready only while no release lookup is in flight
   assign key_ready_out = (state == ST_IDLE);
   assign take = key_valid_in & key_ready_out;
   assign take_make = take & key_make_in;
   assign take_break = take & ~key_make_in;
   assign large_kbd = ctrl[`CTRL_LARGE_BIT];

   // ****************************************
   // Press translation and mode actions
   // ****************************************
   always @* begin
      // Start from current state; restart clears caps and the armed state
      next_code = {1'b0, key_id_in};
      next_caps = host_restart ? 1'b0 : caps;
      next_numlock = numlock;
      next_armed = host_restart ? 1'b0 : armed;
      next_bl_level = bl_level;
      if (key_id_in == `KEY_SECOND) begin
         // Secondary key toggles the armed state, sends nothing
         next_code = `CODE_NONE;
         next_armed = ~next_armed;
      end else if ((key_id_in == `KEY_SHIFT) || (key_id_in == `KEY_CTRL)) begin
         // Modifiers pass through and keep the armed state
         next_code = {1'b0, key_id_in};
      end else if (next_armed) begin
         // Second keystroke of a secondary sequence
         next_armed = 1'b0;
         if (key_id_in == `KEY_F1) begin
            // Caps-lock inversion
            next_code = `CODE_NONE;
            next_caps = ~next_caps;
         end else if (key_id_in == `KEY_F10) begin
            // Backlight or num-lock, never sent to host
            next_code = `CODE_NONE;
            if (ctrl_held) begin
               // Ctrl backlight toggles between off and maximum on either keyboard type
               next_bl_level = (bl_level == `BL_OFF) ? `BL_MAX : `BL_OFF;
            end else if (shift_held) begin
               // Shift selects num-lock
               next_numlock = ~numlock;
            end
            // Plain secondary F10 changes nothing on the backlight
         end else if ((key_id_in >= `KEY_F3) && (key_id_in <= `KEY_F9)) begin
            // Unused secondary functions
            next_code = `CODE_NONE;
         end else if (key_id_in == `KEY_UP) begin
            // Up-arrow becomes page-up
            next_code = `CODE_PGUP;
         end else if (key_id_in == `KEY_Q) begin
            // Q becomes exclamation mark
            next_code = `CODE_EXCL;
         end else if (key_id_in == `KEY_BKSP) begin
            // Backspace becomes insert
            next_code = `CODE_INS;
         end else begin
            // Digits and all others send their row code
            next_code = {1'b0, key_id_in};
         end
      end else if ((key_id_in >= `KEY_D0) && (key_id_in <= `KEY_D9)) begin
         // Unarmed digits send keypad codes
         next_code = `CODE_KP_BASE + {1'b0, key_id_in - `KEY_D0};
      end else if ((key_id_in == `KEY_LIGHT) && large_kbd) begin
         // Large keyboard light key steps the level
         next_code = `CODE_NONE;
         next_bl_level = bl_level + 2'h1;
      end
   end

   // ****************************************
   // Code memory for release events
   // ****************************************
   kbd_code_mem u_code_mem (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_en_in(take_make),
      .wr_addr_in(key_id_in),
      .wr_data_in(next_code),
      .rd_en_in(take_break),
      .rd_addr_in(key_id_in),
      .rd_data_out(brk_code)
   );

   // ****************************************
   // Mode state registers
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         caps <= 1'b0;
         numlock <= 1'b0;
         armed <= 1'b0;
         bl_level <= `BL_OFF;
      end else if (take_make) begin
         // Press applies the translated actions in this cycle
         caps <= next_caps;
         numlock <= next_numlock;
         armed <= next_armed;
         bl_level <= next_bl_level;
      end else if (host_restart) begin
         // Host reboot clears caps and armed state only
         caps <= 1'b0;
         armed <= 1'b0;
      end
   end

   // ****************************************
   // Held modifier tracking
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         shift_held <= 1'b0;
         ctrl_held <= 1'b0;
      end else if (take) begin
         // Make sets, break clears
         if (key_id_in == `KEY_SHIFT) begin
            shift_held <= key_make_in;
         end
         if (key_id_in == `KEY_CTRL) begin
            ctrl_held <= key_make_in;
         end
      end
   end

   // ****************************************
   // Release lookup sequencer
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               // A release waits one cycle for the stored code
               if (take_break) begin
                  state <= ST_BRK;
               end
            end
            ST_BRK: begin
               // Stored code is now on the memory output
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Host code output
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         code_valid_out <= 1'b0;
         code_out <= `CODE_NONE;
         code_make_out <= 1'b0;
      end else begin
         code_valid_out <= 1'b0;
         if (take_make && (next_code != `CODE_NONE)) begin
            // Press code
            code_valid_out <= 1'b1;
            code_out <= next_code;
            code_make_out <= 1'b1;
         end else if ((state == ST_BRK) && (brk_code != `CODE_NONE)) begin
            // Release uses the code sent at press
            code_valid_out <= 1'b1;
            code_out <= brk_code;
            code_make_out <= 1'b0;
         end
      end
   end

   // ****************************************
   // Indicators and backlight
   // ****************************************
   assign caps_led_out = caps;
   assign second_led_out = armed;
   assign numlock_out = numlock;
   assign backlight_level_out = bl_level;
   assign backlight_on_out = (bl_level != `BL_OFF);

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   assign pready_out = 1'b1;
   assign apb_setup = psel_in & ~penable_in;
   assign apb_write = psel_in & penable_in & pwrite_in;
   assign hit_ctrl = (paddr_in == `CTRL_OFS);
   assign hit_status = (paddr_in == `STATUS_OFS);

   // Status word assembled from live state
   assign status_word = {26'h000_0000, bl_level, ~host_rst_n_sync, armed, numlock, caps};

   // Control register write in the access phase
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl <= `CTRL_RST;
      end else if (apb_write && hit_ctrl) begin
         // Only the keyboard type bit is implemented
         ctrl <= {31'h0000_0000, pwdata_in[`CTRL_LARGE_BIT]};
      end
   end

   // Read data and error captured in the setup cycle
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (apb_setup) begin
         // Unmapped addresses answer zero with an error
         pslverr_out <= ~(hit_ctrl | hit_status);
         if (pwrite_in) begin
            prdata_out <= 32'h0000_0000;
         end else if (hit_ctrl) begin
            prdata_out <= ctrl;
         end else if (hit_status) begin
            prdata_out <= status_word;
         end else begin
            prdata_out <= 32'h0000_0000;
         end
      end
   end

endmodule

// >>> kbd_mode_regs.vh
// Constants for the keyboard mode, indicator and backlight controller
`ifndef KBD_MODE_REGS_VH
`define KBD_MODE_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_LARGE_BIT 0
`define CTRL_RST 32'h0000_0000
`define ST_CAPS_BIT 0
`define ST_NUM_BIT 1
`define ST_SEC_BIT 2
`define ST_RESTART_BIT 3
`define ST_BL_LSB 4
`define ST_BL_MSB 5

// ****************************************
// Key identifiers from the matrix scanner
// ****************************************
`define KEY_SECOND 7'h01
`define KEY_SHIFT 7'h02
`define KEY_CTRL 7'h03
`define KEY_D0 7'h10
`define KEY_D9 7'h19
`define KEY_F1 7'h21
`define KEY_F3 7'h23
`define KEY_F9 7'h29
`define KEY_F10 7'h2a
`define KEY_UP 7'h30
`define KEY_Q 7'h31
`define KEY_BKSP 7'h32
`define KEY_LIGHT 7'h33

// ****************************************
// Codes sent to the host
// ****************************************
`define CODE_NONE 8'h00
`define CODE_PGUP 8'h80
`define CODE_EXCL 8'h81
`define CODE_INS 8'h82
`define CODE_KP_BASE 8'h90

// ****************************************
// Backlight levels
// ****************************************
`define BL_OFF 2'h0
`define BL_MAX 2'h1
`define BL_MED 2'h2
`define BL_LOW 2'h3

`endif

// >>> kbd_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module kbd_pin_sync #(
   parameter RST_VAL = 1'b1
) (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Asynchronous pin and filtered level
   input wire pin_in,
   output reg level_out
);

   // Three flip-flop chain
   reg meta;
   reg stage2;
   reg stage3;

   // ****************************************
   // Sample the pin; accept a change once stages two and three agree
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
         level_out <= RST_VAL;
      end else begin
         meta <= pin_in;
         stage2 <= meta;
         stage3 <= stage2;
         // Only agreeing late stages update the level
         if (stage2 == stage3) begin
            level_out <= stage3;
         end
      end
   end

endmodule

// >>> kbd_code_mem.v
// Per-key memory of the code sent at press, read back at release
`timescale 1ns/1ns
`include "kbd_mode_regs.vh"
module kbd_code_mem (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Write port
   input wire wr_en_in,
   input wire [6:0] wr_addr_in,
   input wire [7:0] wr_data_in,
   // Read port, data one cycle later
   input wire rd_en_in,
   input wire [6:0] rd_addr_in,
   output reg [7:0] rd_data_out
);

   // Code storage and per-entry valid flags
   reg [7:0] mem [0:127];
   reg [127:0] valid;

   // ****************************************
   // Storage write, no reset on the array itself
   // ****************************************
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // ****************************************
   // Valid flags and registered read
   // ****************************************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         valid <= 128'h0;
         rd_data_out <= `CODE_NONE;
      end else begin
         if (wr_en_in) begin
            valid[wr_addr_in] <= 1'b1;
         end
         // Unwritten entries read as no code
         if (rd_en_in) begin
            rd_data_out <= valid[rd_addr_in] ? mem[rd_addr_in] : `CODE_NONE;
         end
      end
   end

endmodule

// >>> kbd_mode_ctrl_sva.sv
// Assertion checker for the keyboard mode controller
`timescale 1ns/1ns
`include "kbd_mode_regs.vh"
module kbd_mode_ctrl_sva (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Key events and host restart pin
   input wire key_valid_in,
   input wire [6:0] key_id_in,
   input wire key_make_in,
   input wire key_ready_out,
   input wire host_rst_n_in,
   // Codes and indicators
   input wire code_valid_out,
   input wire [7:0] code_out,
   input wire caps_led_out,
   input wire second_led_out,
   input wire numlock_out,
   input wire [1:0] backlight_level_out,
   input wire backlight_on_out
);
   // Press taken at this edge
   wire press = key_valid_in && key_ready_out && key_make_in;
   // Cycles since the restart pin was last low
   reg [2:0] host_up;
   // Restart long settled, so it cannot clear state now
   wire quiet = host_up == 3'h7;
   // *****************
   // Helper counter
   // *****************
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_up <= 3'h0;
      end else if (!host_rst_n_in) begin
         host_up <= 3'h0;
      end else if (!quiet) begin
         host_up <= host_up + 3'h1;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // *****************
   // Assertions
   // *****************
   reset_clear_a: assert property ($fell(sys_rst_in) |-> !caps_led_out && !second_led_out)
      else $error("lock or mode set after reset");
   caps_toggle_a: assert property (press && key_id_in == `KEY_F1 && second_led_out && quiet
      |=> caps_led_out != $past(caps_led_out)) else $error("caps did not toggle");
   arm_second_a: assert property (press && key_id_in == `KEY_SECOND && !second_led_out && quiet
      |=> second_led_out) else $error("secondary not armed");
   disarm_again_a: assert property (press && key_id_in == `KEY_SECOND && second_led_out
      |=> !second_led_out) else $error("secondary not disarmed");
   armed_q_a: assert property (press && key_id_in == `KEY_Q && second_led_out && quiet
      |=> code_valid_out && code_out == `CODE_EXCL && !second_led_out) else $error("bad armed Q");
   armed_up_a: assert property (press && key_id_in == `KEY_UP && second_led_out && quiet
      |=> code_valid_out && code_out == `CODE_PGUP) else $error("bad armed up");
   armed_bksp_a: assert property (press && key_id_in == `KEY_BKSP && second_led_out && quiet
      |=> code_valid_out && code_out == `CODE_INS) else $error("bad armed backspace");
   digit_pad_a: assert property (press && key_id_in >= `KEY_D0 && key_id_in <= `KEY_D9 && !second_led_out
      |=> code_valid_out && code_out == `CODE_KP_BASE + {1'b0, $past(key_id_in)} - 8'h10)
      else $error("digit not keypad code");
   unused_quiet_a: assert property (press && key_id_in >= `KEY_F3 && key_id_in <= `KEY_F9 && second_led_out
      |=> !code_valid_out && !second_led_out) else $error("unused function acted");
   numlock_hold_a: assert property (!press |=> $stable(numlock_out))
      else $error("num-lock changed without a key");
   light_on_a: assert property (backlight_on_out == (backlight_level_out != `BL_OFF))
      else $error("backlight enable mismatch");
endmodule
bind kbd_mode_ctrl kbd_mode_ctrl_sva kbd_mode_ctrl_sva_inst (.clk_in, .sys_rst_in, .key_valid_in, .key_id_in,
   .key_make_in, .key_ready_out, .host_rst_n_in, .code_valid_out, .code_out, .caps_led_out, .second_led_out,
   .numlock_out, .backlight_level_out, .backlight_on_out);

// >>> host_model.sv
// Host computer model: collects key codes and drives its restart pin
`timescale 1ns/1ns
module host_model (
   // Clock
   input wire clk_in,
   // Codes from the keyboard
   input wire code_valid_in,
   input wire [7:0] code_in,
   input wire code_make_in,
   // Restart request and pin
   input wire reboot_in,
   output wire host_rst_n_out,
   // Last code seen and code count
   output reg [7:0] last_code_out = 8'h00,
   output reg last_make_out = 1'b0,
   output reg [15:0] code_count_out = 16'h0000
);
   // Pin low while the host reboots
   assign host_rst_n_out = !reboot_in;
   // Take each one-cycle code pulse
   always @(posedge clk_in) begin
      if (code_valid_in === 1'b1) begin
         last_code_out <= code_in;
         last_make_out <= code_make_in;
         code_count_out <= code_count_out + 16'h0001;
      end
   end
endmodule

// >>> kbd_mode_ctrl_tb.sv
// Self-checking bench for the keyboard mode controller
`timescale 1ns/1ns
`include "kbd_mode_regs.vh"
module kbd_mode_ctrl_tb;
   // Clock, reset and counters
   reg clk_in = 1'b0;
   reg sys_rst_in = 1'b1;
   integer num_errors = 0;
   integer total_checks = 0;
   integer cycles = 0;
   integer i, j;
   // APB master
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000;
   wire [31:0] prdata;
   wire pready, pslverr;
   reg [31:0] rd;
   reg err, r;
   // Keys, host side, indicators
   reg kvalid = 1'b0, kmake = 1'b0, reboot = 1'b0;
   reg [6:0] kid = 7'h00;
   wire kready, cvalid, cmake, caps, second, numlk, blon, hrst_n, hmake;
   wire [7:0] code, hcode;
   wire [1:0] blev;
   wire [15:0] hcnt;
   reg [15:0] n;
   // Rows: armed first, key id, code (00 means none)
   reg [15:0] rows [0:9];
   always #20 clk_in = ~clk_in;
   kbd_mode_ctrl kbd_mode_ctrl_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .key_valid_in(kvalid), .key_id_in(kid), .key_make_in(kmake),
      .key_ready_out(kready), .host_rst_n_in(hrst_n), .code_valid_out(cvalid), .code_out(code),
      .code_make_out(cmake), .caps_led_out(caps), .second_led_out(second), .numlock_out(numlk),
      .backlight_level_out(blev), .backlight_on_out(blon));
   host_model host_model_inst (.clk_in(clk_in), .code_valid_in(cvalid), .code_in(code), .code_make_in(cmake),
      .reboot_in(reboot), .host_rst_n_out(hrst_n), .last_code_out(hcode), .last_make_out(hmake),
      .code_count_out(hcnt));
   // Hang guard
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   // Compare one value
   task chk(input [32:0] g, input [32:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Wait edges, end settled at a falling edge
   task idle(input integer c);
      begin
         repeat (c) @(posedge clk_in);
         @(negedge clk_in);
      end
   endtask
   // One APB transfer, held until pready
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_in);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_in);
         penable <= 1'b1;
         r = 1'b0;
         while (r !== 1'b1) begin
            @(posedge clk_in);
            r = pready;
            rd = prdata;
            err = pslverr;
         end
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // One key event, held until taken
   task key(input [6:0] id, input mk);
      begin
         @(posedge clk_in);
         kvalid <= 1'b1;
         kid <= id;
         kmake <= mk;
         r = 1'b0;
         while (r !== 1'b1) begin
            @(negedge clk_in);
            r = kready;
            @(posedge clk_in);
         end
         kvalid <= 1'b0;
      end
   endtask
   // Press and release
   task tap(input [6:0] id);
      begin
         key(id, 1'b1);
         key(id, 1'b0);
      end
   endtask
   // Report and end the run
   task finish_test;
      begin
         $display("checks=%0d errors=%0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      rows[0] = {1'b0, `KEY_D0, 8'h90};
      rows[1] = {1'b0, `KEY_D9, 8'h99};
      rows[2] = {1'b1, `KEY_D9, 8'h19};
      rows[3] = {1'b1, `KEY_UP, `CODE_PGUP};
      rows[4] = {1'b1, `KEY_Q, `CODE_EXCL};
      rows[5] = {1'b1, `KEY_BKSP, `CODE_INS};
      rows[6] = {1'b0, `KEY_Q, 8'h31};
      rows[7] = {1'b1, `KEY_F3, 8'h00};
      rows[8] = {1'b1, `KEY_F9, 8'h00};
      rows[9] = {1'b1, `KEY_F1, 8'h00};
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      idle(1);
      chk({caps, second, numlk, blon}, 32'h0);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      // Table of ordinary cases
      for (i = 0; i < 10; i = i + 1) begin
         n = hcnt;
         if (rows[i][15]) begin
            key(`KEY_SECOND, 1'b1);
            idle(0);
            chk(second, 1);
            key(`KEY_SECOND, 1'b0);
         end
         key(rows[i][14:8], 1'b1);
         idle(3);
         chk(second, 0);
         if (rows[i][7:0] != 8'h00) chk({hmake, hcode}, {1'b1, rows[i][7:0]});
         key(rows[i][14:8], 1'b0);
         idle(4);
         if (rows[i][7:0] != 8'h00) chk({hmake, hcode}, {1'b0, rows[i][7:0]});
         else chk(hcnt, n);
      end
      chk(caps, 1);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd[0], 1);
      // Second secondary press disarms
      key(`KEY_SECOND, 1'b1);
      key(`KEY_SECOND, 1'b0);
      key(`KEY_SECOND, 1'b1);
      idle(0);
      chk(second, 0);
      key(`KEY_SECOND, 1'b0);
      tap(`KEY_Q);
      idle(4);
      chk(hcode, 8'h31);
      // Num-lock through shift, plain F10 leaves backlight
      key(`KEY_SHIFT, 1'b1);
      tap(`KEY_SECOND);
      tap(`KEY_F10);
      key(`KEY_SHIFT, 1'b0);
      tap(`KEY_SECOND);
      tap(`KEY_F10);
      idle(1);
      chk({numlk, blon}, 2'b10);
      // Backlight through ctrl, seen at once
      key(`KEY_CTRL, 1'b1);
      tap(`KEY_SECOND);
      key(`KEY_F10, 1'b1);
      idle(0);
      chk({blon, blev}, 3'b101);
      key(`KEY_F10, 1'b0);
      key(`KEY_CTRL, 1'b0);
      // Host restart keeps num-lock
      @(posedge clk_in);
      reboot <= 1'b1;
      idle(10);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'h0000_001a);
      @(posedge clk_in);
      reboot <= 1'b0;
      idle(10);
      chk({numlk, blon, caps}, 3'b110);
      // Large keyboard light key steps from max
      apb(1'b1, `CTRL_OFS, 32'h0000_0001);
      apb(1'b0, `CTRL_OFS, 32'h0);
      chk(rd, 32'h0000_0001);
      for (j = 1; j <= 4; j = j + 1) begin
         tap(`KEY_LIGHT);
         idle(1);
         chk(blev, (j + 1) % 4);
      end
      apb(1'b0, 12'h008, 32'h0);
      chk({err, rd}, 33'h1_0000_0000);
      // Reset in mid run
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      idle(2);
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      idle(1);
      chk({caps, second, numlk, blev}, 32'h0);
      finish_test;
   end
endmodule
